//--- inc/rpp_defs.vh
// Purpose: constants of the reflected-power protection block
// Assumes: 125 MHz clock, power words scaled 16'hFFFF = rated
// Notes:   times kept in their own unit, cycle counts derived
`ifndef RPP_DEFS_VH
`define RPP_DEFS_VH

`define RPP_CLK_HZ       125000000
`define RPP_TICK_US      1000
`define RPP_TICK_CYC     (`RPP_TICK_US * (`RPP_CLK_HZ / 1000000))
`define RPP_TICKS_PER_S  1000
`define RPP_FAST_NS      300
`define RPP_HOLD_MS      300
`define RPP_HOLD_TICKS   (`RPP_HOLD_MS * 1000 / `RPP_TICK_US)
`define RPP_RETURN_S     30
`define RPP_DECAY_S      60

// power thresholds, fraction of rated on 16 bits
`define RPP_FAST_LIM     16'h28F5
`define RPP_PEAK_LIM     16'h28F5
`define RPP_AVG_LIM      16'h0A3D
`define RPP_CB_MIN       16'h051F
`define RPP_CB_SCALE     16'hD99A
`define RPP_FULL         16'hFFFF

// accumulator in units of 1/60, one unit per second of decay
`define RPP_ACC_W        9
`define RPP_ACC_ONE      9'h03C
`define RPP_ACC_CB_TH    9'h096
`define RPP_ACC_MAX      9'h1FF

// filters and ramps
`define RPP_RAMP_SH      4
`define RPP_AVG_SH       12
`define RPP_FOLD_SH      8
`define RPP_REC_SH       6

// power drive
`define RPP_PHASES       9
`define RPP_PDM_PER      360
`define RPP_PDM_CW       10

`endif

//--- rtl/rpp_pdm_gate.v
// Purpose: nine phased pulse-width power drive outputs
// Assumes: duty word 16'hFFFF = full, period a multiple of phase count
// Notes:   kill forces every phase low at the next edge
`timescale 1ns/1ps
`include "rpp_defs.vh"
module rpp_pdm_gate #(
   parameter W      = 16,
   parameter PHASES = `RPP_PHASES,
   parameter PER    = `RPP_PDM_PER,
   parameter CW     = `RPP_PDM_CW
) (
   // clock and reset
   input  wire              mclk_i,
   input  wire              nrst_i,
   // control
   input  wire [W-1:0]      duty_i,
   input  wire              kill_i,
   // drive
   output reg  [PHASES-1:0] pdm_o
);
   localparam [CW-1:0] PER_C = PER[CW-1:0];
   reg  [CW-1:0]   cnt;
   wire [W+CW-1:0] prod = duty_i * PER_C;
   wire [CW-1:0]   thr  = prod[W+CW-1:W];

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= {CW{1'b0}};
      end else if (cnt == PER_C - 1'b1) begin
         cnt <= {CW{1'b0}};
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // phase k offset by k/PHASES of a period, 40 degrees for nine
   genvar k;
   generate
      for (k = 0; k < PHASES; k = k + 1) begin : g_ph
         localparam integer OFS_I = (k * PER) / PHASES;
         localparam [CW:0]  OFS   = OFS_I[CW:0];
         wire [CW:0] s    = {1'b0, cnt} + OFS;
         wire [CW:0] wrap = (s >= {1'b0, PER_C}) ? s - {1'b0, PER_C} : s;
         always @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pdm_o[k] <= 1'b0;
            end else begin
               pdm_o[k] <= !kill_i && (wrap[CW-1:0] < thr); // RULE17
            end
         end
      end
   endgenerate
endmodule

//--- rtl/rpp_top.v
// Purpose: reflected-power protection for an AM transmitter power stage
// Assumes: samples synchronous to mclk_i, current pre-scaled by line impedance
// Notes:   power words are 16'hFFFF = rated; all limits act together
//
// What this block does
// RULE1 - coupler sample over fast limit kills drive
// RULE2 - derive load mismatch from current and voltage
// RULE3 - all protections run at once, always
// RULE4 - calculated peak over 16 percent starts shutback
// RULE5 - shutback holds power zero for 300 ms
// RULE6 - then exponential ramp to lower target
// RULE7 - thirty seconds later normal level control resumes
// RULE8 - each shutback adds one to accumulator
// RULE9 - accumulator decays one sixtieth per second
// RULE10 - accumulator above 2.5 triggers a cutback
// RULE11 - first cutback caps at 85 percent
// RULE12 - each further cutback scales cap by 85 percent
// RULE13 - cap never below 2 percent of carrier
// RULE14 - recover only after accumulator reaches zero
// RULE15 - 4096 ms average over 4 percent folds back
// RULE16 - inhibit input suppresses all power drive
// RULE17 - nine phased drive outputs, 40 degrees apart
// RULE18 - lowest of all limits is applied
// RULE19 - accumulator fixed point makes steps exact
`timescale 1ns/1ps
`include "rpp_defs.vh"
module rpp_top #(
   parameter W           = 16,
   parameter TICK_CYC    = `RPP_TICK_CYC,
   parameter TICKS_PER_S = `RPP_TICKS_PER_S,
   parameter HOLD_TICKS  = `RPP_HOLD_TICKS,
   parameter FAST_LIM    = `RPP_FAST_LIM
) (
   // clock and reset
   input  wire                 mclk_i,
   input  wire                 nrst_i,
   // rf samples
   input  wire signed [W-1:0]  v_smp_i,
   input  wire signed [W-1:0]  i_smp_i,
   input  wire [W-1:0]         cpl_refl_i,
   // level control
   input  wire [W-1:0]         set_point_i,
   input  wire [W-1:0]         alc_i,
   input  wire                 inhibit_i,
   // drive
   output wire [`RPP_PHASES-1:0] pdm_o,
   output reg                  rf_drive_en_o,
   output reg  [W-1:0]         pwr_cmd_o,
   // status
   output reg  [W-1:0]         refl_pwr_o,
   output reg  [W-1:0]         refl_avg_o,
   output reg                  shutback_o,
   output reg                  cutback_o,
   output reg                  foldback_o
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_HOLD = 2'h1;
   localparam [1:0] ST_RAMP = 2'h2;
   localparam AW  = `RPP_ACC_W;
   localparam AVW = W + `RPP_AVG_SH;
   localparam [W-1:0] FULL  = `RPP_FULL;
   localparam [W-1:0] CBMIN = `RPP_CB_MIN;
   localparam [W-1:0] FLIM  = FAST_LIM;

   function [W-1:0] scale85;
      input [W-1:0] x;
      reg [2*W-1:0] p;
      begin
         p = x * `RPP_CB_SCALE;
         scale85 = (p[2*W-1:W] < CBMIN) ? CBMIN : p[2*W-1:W]; // RULE13
      end
   endfunction

   // time base: millisecond tick and second tick
   reg  [23:0] tick_cnt;
   reg  [11:0] ms_cnt;
   wire        tick = (tick_cnt == TICK_CYC - 1);
   wire        sec  = tick && (ms_cnt == TICKS_PER_S - 1);

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_cnt <= 24'h000000;
         ms_cnt   <= 12'h000;
      end else begin
         tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
         if (sec) begin
            ms_cnt <= 12'h000;
         end else if (tick) begin
            ms_cnt <= ms_cnt + 12'h001;
         end
      end
   end

   // reflected wave (v - z0*i)/2 and its power
   wire signed [W:0]     diff = {v_smp_i[W-1], v_smp_i} - {i_smp_i[W-1], i_smp_i};
   reg  signed [W-1:0]   half_q;
   wire signed [2*W-1:0] sq   = half_q * half_q;

   // trips
   reg  fast_trip;
   reg  peak_trip;
   reg  trip_d;
   wire trip_any = fast_trip || peak_trip;
   wire evt      = trip_any && !trip_d;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         half_q     <= {W{1'b0}};
         refl_pwr_o <= {W{1'b0}};
         fast_trip  <= 1'b0;
         peak_trip  <= 1'b0;
         trip_d     <= 1'b0;
      end else begin
         half_q     <= diff[W:1]; // RULE2
         refl_pwr_o <= sq[2*W-2:W-1];
         fast_trip  <= (cpl_refl_i > FLIM); // RULE1
         peak_trip  <= (refl_pwr_o > `RPP_PEAK_LIM); // RULE4
         trip_d     <= trip_any;
      end
   end

   // shutback sequencer
   reg  [1:0]   st;
   reg  [11:0]  hold_cnt;
   reg  [5:0]   sb_sec;
   reg  [W-1:0] sb_lvl;
   reg  [W-1:0] last_sp;
   wire [W-1:0] ramp_tgt = (last_sp < alc_i) ? last_sp : alc_i;
   wire [W-1:0] ramp_gap = ramp_tgt - sb_lvl;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st       <= ST_IDLE;
         hold_cnt <= 12'h000;
         sb_sec   <= 6'h00;
         sb_lvl   <= {W{1'b0}};
         last_sp  <= {W{1'b0}};
      end else if (trip_any) begin
         st       <= ST_HOLD; // RULE4
         hold_cnt <= 12'h000;
         sb_sec   <= 6'h00;
         sb_lvl   <= {W{1'b0}};
         if (st == ST_IDLE) begin
            last_sp <= pwr_cmd_o;
         end
      end else begin
         if (sec) begin
            sb_sec <= sb_sec + 6'h01;
         end
         case (st)
            ST_HOLD: begin
               if (tick) begin
                  hold_cnt <= hold_cnt + 12'h001;
                  if (hold_cnt == HOLD_TICKS - 1) begin
                     st <= ST_RAMP; // RULE5
                  end
               end
            end
            ST_RAMP: begin
               if (tick) begin
                  if (sb_lvl >= ramp_tgt) begin
                     sb_lvl <= ramp_tgt;
                  end else begin
                     sb_lvl <= sb_lvl + (ramp_gap >> `RPP_RAMP_SH) + 1'b1; // RULE6
                  end
               end
               if (sec && sb_sec == `RPP_RETURN_S - 1) begin
                  st <= ST_IDLE; // RULE7
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // shutback accumulator, units of 1/60
   reg  [AW-1:0] acc;
   wire [AW:0]   acc_sum = {1'b0, acc} + {1'b0, `RPP_ACC_ONE};
   wire [AW-1:0] acc_add = acc_sum[AW] ? `RPP_ACC_MAX : acc_sum[AW-1:0];
   wire          cb_evt  = evt && (acc_add > `RPP_ACC_CB_TH); // RULE10 RULE19

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc <= {AW{1'b0}};
      end else if (evt) begin
         acc <= acc_add; // RULE8
      end else if (sec && acc != {AW{1'b0}}) begin
         acc <= acc - 1'b1; // RULE9
      end
   end

   // cutback cap
   reg  [W-1:0] cb_cap;
   reg          cb_act;
   wire [W:0]   cb_up = {1'b0, cb_cap} + (cb_cap >> `RPP_REC_SH) + 1'b1;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cb_cap <= FULL;
         cb_act <= 1'b0;
      end else if (cb_evt) begin
         cb_act <= 1'b1;
         if (!cb_act) begin
            cb_cap <= scale85((st == ST_IDLE) ? pwr_cmd_o : last_sp); // RULE11
         end else begin
            cb_cap <= scale85(cb_cap); // RULE12
         end
      end else if (cb_act && acc == {AW{1'b0}} && tick) begin
         if (cb_up[W]) begin
            cb_cap <= FULL; // RULE14
            cb_act <= 1'b0;
         end else begin
            cb_cap <= cb_up[W-1:0];
         end
      end
   end

   // average reflected power and foldback
   reg  [AVW-1:0] avg_acc;
   reg  [W-1:0]   fold_cap;
   wire [W-1:0]   avg = avg_acc[AVW-1:`RPP_AVG_SH];
   wire           fold = (avg > `RPP_AVG_LIM);
   wire [W-1:0]   fold_step = (fold_cap >> `RPP_FOLD_SH) + 1'b1;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         avg_acc  <= {AVW{1'b0}};
         fold_cap <= FULL;
      end else if (tick) begin
         avg_acc <= avg_acc + refl_pwr_o - avg; // RULE15
         if (fold) begin
            fold_cap <= (fold_cap > fold_step) ? fold_cap - fold_step : {W{1'b0}}; // RULE15
         end else begin
            fold_cap <= (FULL - fold_cap > fold_step) ? fold_cap + fold_step : FULL;
         end
      end
   end

   // lowest of all limits
   reg [W-1:0] next_cmd;
   always @* begin
      next_cmd = set_point_i;
      if (alc_i < next_cmd) begin
         next_cmd = alc_i;
      end
      if (fold_cap < next_cmd) begin
         next_cmd = fold_cap; // RULE18
      end
      if (cb_act && cb_cap < next_cmd) begin
         next_cmd = cb_cap;
      end
      if (st == ST_HOLD || trip_any) begin
         next_cmd = {W{1'b0}};
      end else if (st == ST_RAMP && sb_lvl < next_cmd) begin
         next_cmd = sb_lvl;
      end
   end

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pwr_cmd_o     <= {W{1'b0}};
         rf_drive_en_o <= 1'b0;
         refl_avg_o    <= {W{1'b0}};
         shutback_o    <= 1'b0;
         cutback_o     <= 1'b0;
         foldback_o    <= 1'b0;
      end else begin
         pwr_cmd_o     <= next_cmd; // RULE3
         rf_drive_en_o <= !(fast_trip || st == ST_HOLD); // RULE1
         refl_avg_o    <= avg;
         shutback_o    <= (st != ST_IDLE);
         cutback_o     <= cb_act;
         foldback_o    <= fold;
      end
   end

   rpp_pdm_gate #(
      .W      (W)
   ) u_pdm (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .duty_i (pwr_cmd_o),
      .kill_i (trip_any || st == ST_HOLD || inhibit_i), // RULE16 RULE1
      .pdm_o  (pdm_o)
   );
endmodule

//--- test/rpp_checker.sv
// Purpose: port-level assertions for rpp_top
// Assumes: one clock domain, reset async active low
// Notes:   bound to rpp_top from the testbench top file
`timescale 1ns/1ps
module rpp_checker #(
   parameter FAST_LIM = 16'h28F5
) (
   // clock and reset
   input wire               mclk_i,
   input wire               nrst_i,
   // samples and level control
   input wire signed [15:0] v_smp_i,
   input wire signed [15:0] i_smp_i,
   input wire [15:0]        cpl_refl_i,
   input wire [15:0]        set_point_i,
   input wire [15:0]        alc_i,
   input wire               inhibit_i,
   // drive and status
   input wire [8:0]         pdm_o,
   input wire               rf_drive_en_o,
   input wire [15:0]        pwr_cmd_o,
   input wire [15:0]        refl_pwr_o,
   input wire [15:0]        refl_avg_o,
   input wire               shutback_o,
   input wire               cutback_o,
   input wire               foldback_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   fast_trip_a: assert property (cpl_refl_i > FAST_LIM |-> ##2 !rf_drive_en_o && pwr_cmd_o == 16'h0000)
      else $error("drive not cut after coupler trip");
   fast_pdm_a: assert property (cpl_refl_i > FAST_LIM |-> ##2 pdm_o == 9'h000)
      else $error("some phase still driven after trip");
   peak_trip_a: assert property (refl_pwr_o > 16'h28F5 |-> ##2 pwr_cmd_o == 16'h0000)
      else $error("power not zero after peak trip");
   hold_zero_a: assert property ($rose(shutback_o) |-> (pwr_cmd_o == 16'h0000)[*8])
      else $error("power left zero too early");
   rf_hold_a: assert property ($rose(shutback_o) |-> !rf_drive_en_o ##1 !rf_drive_en_o)
      else $error("rf drive on during hold");
   inhibit_a: assert property (inhibit_i |=> pdm_o == 9'h000)
      else $error("drive active while inhibited");
   min_limit_a: assert property (pwr_cmd_o <= $past(set_point_i) && pwr_cmd_o <= $past(alc_i))
      else $error("power above set point or level control");
   refl_match_a: assert property ((v_smp_i == i_smp_i)[*3] |-> refl_pwr_o == 16'h0000)
      else $error("reflection seen on matched load");
   fold_flag_a: assert property (refl_avg_o > 16'h0A3D |-> ##[0:1] foldback_o)
      else $error("foldback flag missing");
   resume_a: assert property ($fell(shutback_o) |-> rf_drive_en_o)
      else $error("rf drive off after shutback ends");
   cover property ($rose(shutback_o));
   cover property ($rose(cutback_o));
   cover property ($fell(cutback_o));
   cover property ($rose(foldback_o));
endmodule

//--- test/rpp_probe_model.sv
// Purpose: rf voltage, current and coupler samples
// Assumes: samples change just after the rising edge
// Notes:   mode 0 matched load, 1 arc, 2 coupler spike, 3 mild mismatch
`timescale 1ns/1ps
module rpp_probe_model (
   // clock and control
   input  wire               mclk_i,
   input  wire [1:0]         mode_i,
   // samples
   output reg signed [15:0]  v_smp_o,
   output reg signed [15:0]  i_smp_o,
   output reg [15:0]         cpl_refl_o
);
   reg [15:0] phase;
   initial begin
      phase = 16'h0000;
      v_smp_o = 16'h0000;
      i_smp_o = 16'h0000;
      cpl_refl_o = 16'h0000;
   end
   // carrier stand-in, never constant so stale values show
   always @(posedge mclk_i) begin
      phase <= phase + 16'h0801;
      v_smp_o <= #1 (mode_i == 2'h1) ? 16'h7000 : (mode_i == 2'h3) ? 16'h4000 : phase;
      i_smp_o <= #1 (mode_i == 2'h1) ? 16'h9000 : (mode_i == 2'h3) ? 16'hC000 : phase;
      cpl_refl_o <= #1 (mode_i == 2'h2) ? 16'hFFFF : {6'h00, phase[9:0]};
   end
endmodule

//--- test/reflected_power_protection_tb.sv
// Purpose: self-checking bench for rpp_top
// Assumes: 1 tick = 4 cycles, 1 s = 10 ticks, hold 3 ticks
// Notes:   probe model supplies all rf samples
`timescale 1ns/1ps
module reflected_power_protection_tb;
   reg                mclk_i, nrst_i, inhibit_i;
   reg         [15:0] set_point_i, alc_i;
   reg         [1:0]  mode;
   reg         [47:0] rows [0:3];
   wire signed [15:0] v_smp, i_smp;
   wire        [15:0] cpl, pwr_cmd_o, refl_pwr_o, refl_avg_o;
   wire        [8:0]  pdm_o;
   wire               rf_drive_en_o, shutback_o, cutback_o, foldback_o;
   integer            fail_count, checks_done, k, n;

   rpp_probe_model probe (.mclk_i(mclk_i), .mode_i(mode), .v_smp_o(v_smp), .i_smp_o(i_smp), .cpl_refl_o(cpl));
   rpp_top #(.TICK_CYC(4), .TICKS_PER_S(10), .HOLD_TICKS(3)) dut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .v_smp_i(v_smp), .i_smp_i(i_smp), .cpl_refl_i(cpl),
      .set_point_i(set_point_i), .alc_i(alc_i), .inhibit_i(inhibit_i), .pdm_o(pdm_o),
      .rf_drive_en_o(rf_drive_en_o), .pwr_cmd_o(pwr_cmd_o), .refl_pwr_o(refl_pwr_o),
      .refl_avg_o(refl_avg_o), .shutback_o(shutback_o), .cutback_o(cutback_o), .foldback_o(foldback_o));

   task step(input integer c);
      repeat (c) @(posedge mclk_i);
      #1;
   endtask
   task chk(input [15:0] got, input [15:0] exp, input [8*16-1:0] what);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: %0s got %h want %h", $time, what, got, exp);
      end
   endtask
   task chk_range(input [15:0] got, input [15:0] lo, input [15:0] hi, input [8*16-1:0] what);
      checks_done = checks_done + 1;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: %0s got %h", $time, what, got);
      end
   endtask
   // two cycles of mismatched voltage and current
   task arc;
      mode = 2'h1;
      step(2);
      mode = 2'h0;
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   initial begin
      #400000;
      fail_count = fail_count + 1;
      close_out;
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      nrst_i = 1'b0;
      inhibit_i = 1'b0;
      mode = 2'h0;
      set_point_i = 16'hFFFF;
      alc_i = 16'hFFFF;
      rows[0] = {16'hFFFF, 16'hFFFF, 16'hFFFF};
      rows[1] = {16'h8000, 16'hFFFF, 16'h8000};
      rows[2] = {16'hFFFF, 16'h1234, 16'h1234};
      rows[3] = {16'h0000, 16'hFFFF, 16'h0000};
      step(2);
      chk({15'h0000, rf_drive_en_o}, 16'h0000, "rf in reset");
      chk(pwr_cmd_o, 16'h0000, "power in reset");
      nrst_i = 1'b1;
      step(2);
      chk({15'h0000, rf_drive_en_o}, 16'h0001, "rf after reset");
      for (k = 0; k < 4; k = k + 1) begin
         {set_point_i, alc_i} = rows[k][47:16];
         step(3);
         chk(pwr_cmd_o, rows[k][15:0], "power command");
         chk(refl_pwr_o, 16'h0000, "matched refl");
      end
      set_point_i = 16'hFFFF;
      step(3);
      inhibit_i = 1'b1;
      step(2);
      chk({7'h00, pdm_o}, 16'h0000, "inhibited pdm");
      inhibit_i = 1'b0;
      mode = 2'h2;
      step(1);
      mode = 2'h0;
      step(3);
      chk({15'h0000, rf_drive_en_o}, 16'h0000, "fast trip rf");
      chk(pwr_cmd_o, 16'h0000, "fast trip power");
      step(2);
      chk({15'h0000, shutback_o}, 16'h0001, "shutback on");
      step(1000);
      chk({15'h0000, shutback_o}, 16'h0001, "before 30 s");
      step(300);
      chk({15'h0000, shutback_o}, 16'h0000, "after 30 s");
      chk(pwr_cmd_o, 16'hFFFF, "full power back");
      arc;
      step(6);
      chk(pwr_cmd_o, 16'h0000, "peak trip power");
      chk({15'h0000, shutback_o}, 16'h0001, "peak shutback");
      step(40);
      arc;
      step(40);
      chk({15'h0000, cutback_o}, 16'h0000, "two events");
      arc;
      step(40);
      chk({15'h0000, cutback_o}, 16'h0001, "three events");
      step(1300);
      chk_range(pwr_cmd_o, 16'hD998, 16'hD999, "cutback cap");
      chk({15'h0000, cutback_o}, 16'h0001, "cap held");
      // fourth event while the cap stands scales it again
      arc;
      step(1300);
      chk_range(pwr_cmd_o, 16'hB8F4, 16'hB8F5, "second cap");
      n = 0;
      while (cutback_o !== 1'b0 && n < 12000) begin
         step(1);
         n = n + 1;
      end
      chk_range(n[15:0], 16'h1770, 16'h2EDF, "recovery wait");
      step(3);
      chk(pwr_cmd_o, 16'hFFFF, "restored power");
      // steady mismatch under the peak limit, average climbs
      mode = 2'h3;
      step(7000);
      chk(refl_pwr_o, 16'h2000, "partial refl");
      chk({15'h0000, foldback_o}, 16'h0001, "foldback on");
      chk_range(refl_avg_o, 16'h0A3E, 16'h2000, "average refl");
      chk_range(pwr_cmd_o, 16'h0000, 16'hFFFE, "folded power");
      // reset in mid-run, then a low set point and three quick arcs
      mode = 2'h0;
      nrst_i = 1'b0;
      step(2);
      chk({15'h0000, foldback_o}, 16'h0000, "fold in reset");
      chk(refl_avg_o, 16'h0000, "avg in reset");
      nrst_i = 1'b1;
      set_point_i = 16'h0600;
      step(1);
      chk(pwr_cmd_o, 16'h0600, "first edge power");
      for (k = 0; k < 3; k = k + 1) begin
         arc;
         step(40);
      end
      chk({15'h0000, cutback_o}, 16'h0001, "fresh cutback");
      step(1300);
      chk(pwr_cmd_o, 16'h051F, "cap floor");
      close_out;
   end
endmodule

bind rpp_top rpp_checker #(.FAST_LIM(FAST_LIM)) chk_u (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .v_smp_i(v_smp_i), .i_smp_i(i_smp_i), .cpl_refl_i(cpl_refl_i),
   .set_point_i(set_point_i), .alc_i(alc_i), .inhibit_i(inhibit_i), .pdm_o(pdm_o),
   .rf_drive_en_o(rf_drive_en_o), .pwr_cmd_o(pwr_cmd_o), .refl_pwr_o(refl_pwr_o),
   .refl_avg_o(refl_avg_o), .shutback_o(shutback_o), .cutback_o(cutback_o), .foldback_o(foldback_o));
